/* File: core/usb_fifo_access_control.sv */
// apb register block for core access to the usb endpoint fifos
`include "usb_fifo_access_map.svh"
// Behaviour
// [R01] empty packet sets flag, fifo read clears
// [R02] ready flag shows selected fifo accessible
// [R03] core sets direction one for writes
// [R04] direction falling marks end of write
// [R05] direction low during read, then one
// [R06] request bit claims the selected fifo
// [R07] enable bits for endpoint 1-3 out fifos
// [R08] data pid toggle bit, read-write
// [R09] setup flag set by hardware, firmware clears
// [R10] clear empties fifo; host read gets underrun
// [R11] core drops request after access completes
// [R12] double buffer selects for ep4 out, ep3 in
module usb_fifo_access_control
   import usb_fifo_access_pkg::*;
(
   // apb clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // serial interface engine side
   input  wire sie_event_t  sie_evt,
   input  wire logic        core_fifo_read,
   output logic             force_tx_err,
   output logic             fifo_flush,
   output logic [3:1]       ep_out_enable,
   output logic             data_pid_toggle,
   output logic             ep4_out_double_buffer_select,
   output logic             ep3_in_double_buffer_select,
   // interrupt
   output logic             irq
);
   // whole block state
   typedef struct packed {
      logic [7:0]  misc;       // fifo_access_misc_control, bit 6 mirrored
      logic [7:0]  outen;      // out_fifo_enable
      logic [3:0]  irq_st;     // sticky events
      logic [3:0]  irq_mask;   // interrupt enables
      logic        underrun;   // fifo was cleared, host read must fail
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        txerr;
      logic        flush;
      logic        irq;
   } blk_state_t;

   blk_state_t  s_ff, nxt_s;
   logic        rdy;           // ready from tracker
   logic        acc_done;      // one-cycle transfer end pulse
   logic        wr_en;         // apb write in access phase
   logic        rd_en;         // apb read in access phase
   logic        acc_open;      // first access cycle, answer still pending
   logic [3:0]  evt;           // events this cycle
   logic [7:0]  misc_view;     // misc as software reads it

   // handshake tracker
   fifo_ready_tracker u_tracker (
      .pclk      (pclk),
      .presetn   (presetn),
      .request   (s_ff.misc[`MISC_REQ_BIT]),
      .dir_write (s_ff.misc[`MISC_DIR_BIT]),   // [R03] [R05]
      .clear     (s_ff.misc[`MISC_CLEAR_BIT]),
      .ready     (rdy),
      .done      (acc_done)
   );

   // one wait state: the answer is decoded in the first access cycle and stands in
   // the next; a write lands only at the edge that completes the transfer, so a
   // request the master still holds is never taken twice
   assign acc_open = psel & penable & ~s_ff.pready;
   assign wr_en    = psel & penable & pwrite & s_ff.pready;
   assign rd_en    = acc_open & ~pwrite;
   // bit 4 of misc is the ep4 select; ready and zlp are read-only
   assign misc_view = {s_ff.misc[7], rdy, s_ff.misc[5:0]};

   // next state of registers, flags and apb answer
   always_comb begin
      nxt_s         = s_ff;
      evt           = 4'h0;
      nxt_s.pready  = 1'b0;
      nxt_s.pslverr = 1'b0;
      nxt_s.prdata  = 32'h0000_0000;
      nxt_s.txerr   = 1'b0;
      nxt_s.flush   = 1'b0;
      // software writes; flags that hardware sets are handled afterwards
      if (wr_en) begin
         if (paddr == `MISC_CTRL_OFS) begin
            // keep zlp; firmware may clear setup but never set it
            nxt_s.misc[4:0] = pwdata[4:0];      // [R12]
            if (!pwdata[`MISC_SETUP_BIT]) begin
               nxt_s.misc[`MISC_SETUP_BIT] = 1'b0; // [R09]
            end
         end else if (paddr == `OUT_EN_OFS) begin
            nxt_s.outen = {4'h0, pwdata[3:0]};  // [R07] [R08]
         end else if (paddr == `IRQ_STATUS_OFS) begin
            nxt_s.irq_st = s_ff.irq_st & ~pwdata[3:0];
         end else if (paddr == `IRQ_MASK_OFS) begin
            nxt_s.irq_mask = pwdata[3:0];
         end
      end
      // every access is answered once; an unmapped address is refused
      if (acc_open) begin
         nxt_s.pready = 1'b1;
         if (paddr != `MISC_CTRL_OFS && paddr != `OUT_EN_OFS &&
             paddr != `IRQ_STATUS_OFS && paddr != `IRQ_MASK_OFS) begin
            nxt_s.pslverr = 1'b1;
         end
      end
      // reads
      if (rd_en) begin
         if (paddr == `MISC_CTRL_OFS) begin
            nxt_s.prdata = {24'h00_0000, misc_view};
         end else if (paddr == `OUT_EN_OFS) begin
            nxt_s.prdata = {24'h00_0000, s_ff.outen};
         end else if (paddr == `IRQ_STATUS_OFS) begin
            nxt_s.prdata = {28'h000_0000, s_ff.irq_st};
         end else if (paddr == `IRQ_MASK_OFS) begin
            nxt_s.prdata = {28'h000_0000, s_ff.irq_mask};
         end else begin
            nxt_s.pslverr = 1'b1;
         end
      end
      // core fifo read clears zlp; a new empty packet in the same cycle wins
      if (core_fifo_read) begin
         nxt_s.misc[`MISC_ZLP_BIT] = 1'b0;        // [R01]
      end
      if (sie_evt.zlp_rx) begin
         nxt_s.misc[`MISC_ZLP_BIT] = 1'b1;        // [R01]
         evt[`IRQ_ZLP_BIT]         = 1'b1;
      end
      if (sie_evt.setup_rx) begin
         nxt_s.misc[`MISC_SETUP_BIT] = 1'b1;      // [R09]
         evt[`IRQ_SETUP_BIT]         = 1'b1;
      end
      // host reading an emptied fifo gets the error once
      if (sie_evt.host_in_read && s_ff.underrun) begin
         nxt_s.txerr    = 1'b1;                   // [R10]
         nxt_s.underrun = 1'b0;
         evt[`IRQ_UNDERRUN_BIT] = 1'b1;
      end
      // clear request: flush fifo once, arm underrun for the host;
      // placed last so a new clear re-arms even when an error goes out now
      if (s_ff.misc[`MISC_CLEAR_BIT]) begin
         nxt_s.flush    = 1'b1;                   // [R10]
         nxt_s.underrun = 1'b1;
         nxt_s.misc[`MISC_CLEAR_BIT] = 1'b0;      // self clearing after one flush
      end
      evt[`IRQ_DONE_BIT] = acc_done;              // [R04]
      // sticky status, set wins over clear
      nxt_s.irq_st = nxt_s.irq_st | evt;
      nxt_s.irq    = |(nxt_s.irq_st & nxt_s.irq_mask);
   end

   // one register for all state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_ff <= '{misc: `MISC_RESET, outen: `OUT_EN_RESET, irq_st: `IRQ_RESET,
                   irq_mask: `IRQ_RESET, underrun: 1'b0, prdata: 32'h0000_0000,
                   pready: 1'b0, pslverr: 1'b0, txerr: 1'b0, flush: 1'b0, irq: 1'b0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   // outputs straight from flip-flops
   assign prdata                       = s_ff.prdata;
   assign pready                       = s_ff.pready;
   assign pslverr                      = s_ff.pslverr;
   assign force_tx_err                 = s_ff.txerr;
   assign fifo_flush                   = s_ff.flush;
   assign ep_out_enable                = s_ff.outen[`OUT_EP3_BIT:`OUT_EP1_BIT]; // [R07]
   assign data_pid_toggle              = s_ff.outen[`OUT_TOGGLE_BIT];          // [R08]
   assign ep4_out_double_buffer_select = s_ff.misc[`MISC_EP4DB_BIT];           // [R12]
   assign ep3_in_double_buffer_select  = s_ff.misc[`MISC_EP3DB_BIT];           // [R12]
   assign irq                          = s_ff.irq;
endmodule // usb_fifo_access_control

/* File: include/usb_fifo_access_map.svh */
// register offsets, field positions, reset values and timing counts of the fifo access block
`ifndef USB_FIFO_ACCESS_MAP_SVH
`define USB_FIFO_ACCESS_MAP_SVH
// byte offsets on apb
`define MISC_CTRL_OFS    12'h000
`define OUT_EN_OFS       12'h004
`define IRQ_STATUS_OFS   12'h008
`define IRQ_MASK_OFS     12'h00C
// misc control bit positions
`define MISC_ZLP_BIT     7
`define MISC_READY_BIT   6
`define MISC_SETUP_BIT   5
`define MISC_EP4DB_BIT   4
`define MISC_EP3DB_BIT   3
`define MISC_CLEAR_BIT   2
`define MISC_DIR_BIT     1
`define MISC_REQ_BIT     0
// out fifo enable positions
`define OUT_TOGGLE_BIT   0
`define OUT_EP1_BIT      1
`define OUT_EP3_BIT      3
// interrupt status bit positions
`define IRQ_ZLP_BIT      0
`define IRQ_SETUP_BIT    1
`define IRQ_UNDERRUN_BIT 2
`define IRQ_DONE_BIT     3
// reset values
`define MISC_RESET       8'h00
`define OUT_EN_RESET     8'h00
`define IRQ_RESET        4'h0
// cycles the tracker spends in ACC_WAIT before the fifo shows ready after a request
`define READY_DELAY      2'h2
`endif

/* File: include/usb_fifo_access_pkg.sv */
// types shared by the fifo access block
package usb_fifo_access_pkg;
   // events reported by the serial interface engine side
   typedef struct packed {
      logic zlp_rx;       // host sent an empty packet
      logic setup_rx;     // fifo holds a setup request
      logic host_in_read; // host tried to read an in fifo
   } sie_event_t;
   // access handshake state
   typedef enum logic [1:0] {ACC_IDLE, ACC_WAIT, ACC_BUSY, ACC_DONE} acc_state_t;
   // ready tracker state
   typedef struct packed {
      acc_state_t st;
      logic [1:0] cnt;
      logic       ready;
      logic       done;
   } ready_state_t;
endpackage

/* File: core/fifo_ready_tracker.sv */
// tracks the request and direction handshake and the fifo ready flag
`include "usb_fifo_access_map.svh"
module fifo_ready_tracker
   import usb_fifo_access_pkg::*;
(
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // handshake bits from the control register
   input  wire logic request,
   input  wire logic dir_write,
   input  wire logic clear,
   // status back to the register
   output logic      ready,
   output logic      done
);
   ready_state_t s_ff, nxt_s;

   // handshake walk; ready drops when the transfer ends
   always_comb begin
      nxt_s      = s_ff;
      nxt_s.done = 1'b0;
      case (s_ff.st)
         ACC_IDLE: begin
            if (request) begin                 // [R06]
               nxt_s.st  = ACC_WAIT;
               nxt_s.cnt = `READY_DELAY;
            end
         end
         ACC_WAIT: begin
            if (!request) begin
               nxt_s.st = ACC_IDLE;
            end else if (s_ff.cnt == 2'h1 || clear) begin
               // clear forces ready even when the fifo was busy
               nxt_s.st    = ACC_BUSY;
               nxt_s.ready = 1'b1;              // [R02] [R10]
               nxt_s.cnt   = 2'h0;              // no write direction seen yet in this access
            end else begin
               nxt_s.cnt = s_ff.cnt - 2'h1;
            end
         end
         ACC_BUSY: begin
            // write ends when direction falls while request still high
            if (!request || (dir_write == 1'b0 && s_ff.cnt == 2'h1)) begin  // [R04]
               nxt_s.st    = ACC_DONE;
               nxt_s.ready = 1'b0;
               nxt_s.done  = 1'b1;
            end
            nxt_s.cnt = dir_write ? 2'h1 : 2'h0; // remember a write was in flight
         end
         default: begin
            // wait for the core to drop request
            if (!request) begin                 // [R11]
               nxt_s.st = ACC_IDLE;
            end
         end
      endcase
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_ff <= '{st: ACC_IDLE, cnt: 2'h0, ready: 1'b0, done: 1'b0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign ready = s_ff.ready;
   assign done  = s_ff.done;
endmodule // fifo_ready_tracker

/* File: test/usb_fifo_access_props.sv */
// port checker of the fifo access block
`include "usb_fifo_access_map.svh"
module usb_fifo_access_props
   import usb_fifo_access_pkg::*;
(
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // engine side
   input wire sie_event_t  sie_evt,
   input wire logic        force_tx_err,
   input wire logic        fifo_flush,
   input wire logic [3:1]  ep_out_enable,
   input wire logic        data_pid_toggle,
   input wire logic        ep4_out_double_buffer_select,
   input wire logic        ep3_in_double_buffer_select
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // access phase still waiting for its answer
   sequence acc_s;
      psel && penable && !pready;
   endsequence
   // access phase at the edge that completes it
   sequence done_s;
      psel && penable && pready;
   endsequence
   // completed write to one register; it lands at this edge
   sequence wr_s(logic [11:0] a);
      done_s ##0 (pwrite && paddr == a);
   endsequence
   access_answer_a: assert property (acc_s |=> pready) else $error("no answer");
   pready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000) else $error("stray data");
   slverr_qual_a: assert property (pslverr |-> pready) else $error("stray error");
   // error flag must match the decode of the address just taken
   unmapped_err_a: assert property (acc_s |=> pslverr != ($past(paddr) inside
      {`MISC_CTRL_OFS, `OUT_EN_OFS, `IRQ_STATUS_OFS, `IRQ_MASK_OFS})) else $error("bad decode");
   flush_clear_a: assert property (wr_s(`MISC_CTRL_OFS) ##0 pwdata[`MISC_CLEAR_BIT]
      |-> ##[1:3] fifo_flush) else $error("no flush");
   flush_pulse_a: assert property (fifo_flush |=> !fifo_flush) else $error("long flush");
   out_enable_wr_a: assert property (wr_s(`OUT_EN_OFS) |=>
      {ep_out_enable, data_pid_toggle} == $past(pwdata[3:0])) else $error("enable lost");
   dbl_buffer_wr_a: assert property (wr_s(`MISC_CTRL_OFS) |=>
      {ep4_out_double_buffer_select, ep3_in_double_buffer_select} == $past(pwdata[4:3]))
      else $error("buffer select lost");
   underrun_cause_a: assert property (force_tx_err |->
      $past(sie_evt.host_in_read) ##1 !force_tx_err) else $error("stray underrun");
endmodule // usb_fifo_access_props
bind usb_fifo_access_control usb_fifo_access_props chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .sie_evt(sie_evt), .force_tx_err(force_tx_err), .fifo_flush(fifo_flush),
   .ep_out_enable(ep_out_enable), .data_pid_toggle(data_pid_toggle),
   .ep4_out_double_buffer_select(ep4_out_double_buffer_select),
   .ep3_in_double_buffer_select(ep3_in_double_buffer_select)
);

/* File: test/sie_host_model.sv */
// far side model: host traffic seen through the serial interface engine
module sie_host_model
   import usb_fifo_access_pkg::*;
(
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // engine events into the block
   output sie_event_t sie_evt,
   // underrun notice from the block
   input  wire logic force_tx_err
);
   timeunit 1ns;
   timeprecision 1ps;
   int underruns = 0; // underrun notices the host received
   initial sie_evt = '0;
   // one-cycle event, launched after an edge; gap lets the host be slow
   task automatic send(input sie_event_t e, input int gap);
      repeat (gap) @(posedge pclk);
      @(posedge pclk);
      sie_evt <= e;
      @(posedge pclk);
      sie_evt <= '0;
   endtask
   // host tallies every underrun answer it gets
   always @(posedge pclk) if (presetn && force_tx_err === 1'b1) underruns++;
endmodule // sie_host_model

/* File: test/test_usb_fifo_access_control.sv */
// self-checking bench of the fifo access block
`include "usb_fifo_access_map.svh"
module test_usb_fifo_access_control import usb_fifo_access_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
   logic        pready, pslverr, rerr, txerr, flush, tgl, db4, db3, irq;
   logic        cfr = 1'b0;  // core read of the fifo
   logic [3:1]  ep_en;
   sie_event_t  evt;
   int          fail_count = 0, compares = 0, flushes = 0;
   logic [7:0]  seed = 8'h63;
   usb_fifo_access_control dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sie_evt(evt), .core_fifo_read(cfr),
      .force_tx_err(txerr), .fifo_flush(flush), .ep_out_enable(ep_en),
      .data_pid_toggle(tgl), .ep4_out_double_buffer_select(db4),
      .ep3_in_double_buffer_select(db3), .irq(irq));
   sie_host_model host (.pclk(pclk), .presetn(presetn), .sie_evt(evt), .force_tx_err(txerr));
   initial begin
      forever #2 pclk = ~pclk;
   end
   // flush pulses counted as the fifo would see them
   always @(posedge pclk) if (flush === 1'b1) flushes++;
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // only the toggle bit and three enable bits exist; the rest read as zero
   function automatic logic [31:0] outen(input logic [7:0] d);
      return {28'h000_0000, d[3:0]};
   endfunction
   task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic chk_b(input logic g, input logic e);
      chk_w({31'h0, g}, {31'h0, e});
   endtask
   task automatic wrap_up();
      if (fail_count == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end
      else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // one apb transfer; data and error are taken at the answering edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // no cycle count is assumed: the watchdog ends a wait that never answers
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 16; i += 4) begin
         apb(1'b0, i[11:0], 32'h0);
         chk_w(rdat, 32'h0000_0000);
      end
      chk_w({25'h0, ep_en, tgl, db4, db3, irq}, 32'h0000_0000);
      apb(1'b0, 12'h010, 32'h0);
      chk_w({rdat[30:0], rerr}, 32'h0000_0001);
      // random enables, then every bit set including reserved ones
      for (int k = 0; k < 7; k++) begin
         seed = (k == 6) ? 8'hFF : lfsr(seed);
         apb(1'b1, `OUT_EN_OFS, {24'h00_0000, seed});
         apb(1'b0, `OUT_EN_OFS, 32'h0);
         chk_w(rdat, outen(seed));
         chk_w({28'h000_0000, ep_en, tgl}, outen(seed));
      end
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, `MISC_CTRL_OFS, {27'h0, i[1:0], 3'h0});
         apb(1'b0, `MISC_CTRL_OFS, 32'h0);
         chk_w({28'h0, db4, db3, rdat[4:3]}, {28'h0, i[1:0], i[1:0]});
      end
      host.send(3'b100, 0);
      apb(1'b0, `MISC_CTRL_OFS, 32'h0);
      chk_b(rdat[`MISC_ZLP_BIT], 1'b1);
      chk_b(irq, 1'b0);
      apb(1'b1, `IRQ_MASK_OFS, 32'h0000_000F);
      repeat (2) @(posedge pclk);
      chk_b(irq, 1'b1);
      cfr <= 1'b1;
      @(posedge pclk);
      cfr <= 1'b0;
      apb(1'b0, `MISC_CTRL_OFS, 32'h0);
      chk_b(rdat[`MISC_ZLP_BIT], 1'b0);
      apb(1'b1, `IRQ_STATUS_OFS, 32'h0000_0001);
      repeat (2) @(posedge pclk);
      chk_b(irq, 1'b0);
      host.send(3'b010, 3);
      apb(1'b0, `MISC_CTRL_OFS, 32'h0);
      chk_b(rdat[`MISC_SETUP_BIT], 1'b1);
      // write, end by dropping direction, release; then read and finish
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, `MISC_CTRL_OFS, {30'h0, 2'(12'h347 >> (2 * i))});
         repeat (4) @(posedge pclk); // ready follows the request a few cycles later
         apb(1'b0, `MISC_CTRL_OFS, 32'h0);
         if (i != 4) begin
            chk_b(rdat[`MISC_READY_BIT], 1'(6'h09 >> i));
         end
      end
      chk_b(rdat[`MISC_SETUP_BIT], 1'b0);
      apb(1'b1, `MISC_CTRL_OFS, 32'h0000_0004);
      repeat (3) @(posedge pclk);
      chk_w(32'(flushes), 32'h0000_0001);
      apb(1'b0, `MISC_CTRL_OFS, 32'h0);
      chk_b(rdat[`MISC_CLEAR_BIT], 1'b0);
      host.send(3'b001, 0);
      host.send(3'b001, 1);
      repeat (3) @(posedge pclk);
      chk_w(32'(host.underruns), 32'h0000_0001);
      apb(1'b0, `IRQ_STATUS_OFS, 32'h0);
      chk_w(rdat, 32'h0000_000E);
      wrap_up();
   end
   initial begin
      repeat (3000) @(posedge pclk);
      fail_count++;
      wrap_up();
   end
endmodule // test_usb_fifo_access_control
